// [logic/amr_mode_regs.sv]
// Mode control register bank of a stereo audio converter.
// Assumes the three-wire control port pins arrive asynchronously to clock,
// and zero detection results come from the datapath on clock.
//
// What this block does
// - Direction bit one reads, zero writes.
// - Registers 22 and 23 ignore writes.
// - Eight indices 16..23, data in bits 7..0.
// - DAC operation bit, default enabled.
// - Readback output enable bit, default disabled.
// - Bypass single_channel_mode/stereo select, default single_channel_mode.
// - Rolloff select sharp/slow, default sharp.
// - Infinite zero mute enable, default off.
// - Soft system reset bit, default normal.
// - One-bit stream interface enable, default off.
// - Internal filter bypass, default filter on.
// - Single_channel_mode select and single_channel_mode channel source.
// - Oversampling field 64/128/32, default 64.
// - Stream mode: oversampling field sets FIR rate.
// - Stream mode: de-emphasis field sets FIR performance.
// - PCM zero output enable, default on.
// - Stream zero output enable field, default off.
// - Per-channel zero flags in register 22.
// - Five-bit device number in register 23.
// - Sixteen-bit word: direction, index, data.
// - Read data after clock 8, write after 16.
// - Attenuation levels reset to all ones.
`timescale 1ns/1ps
`default_nettype none
module amr_mode_regs #(
  parameter logic [4:0] DEVICE_NUMBER = amr_pkg::DEFAULT_DEVICE_NUMBER
) (
  // System clock and reset
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  // Control port pins
  input  wire logic                   control_bit_clock,
  input  wire logic                   control_select_n,
  input  wire logic                   control_serial_in,
  // Zero detection from the datapath
  input  wire logic                   left_zero_detect,
  input  wire logic                   right_zero_detect,
  // Zero pins; left carries readback when enabled
  output logic                        left_zero_pin,
  output logic                        right_zero_pin,
  // Control outputs to the datapath
  output logic [7:0]                  left_atten_level,
  output logic [7:0]                  right_atten_level,
  output amr_pkg::amr_format_ctl_s    format_ctl,
  output amr_pkg::amr_output_ctl_s    output_ctl,
  output amr_pkg::amr_system_ctl_s    system_ctl
);

  // Registers
  logic [7:0] reg_q [amr_pkg::NUM_RW_REGS];
  logic [7:0] flags_q;
  logic       word_seen_q;
  logic       req_seen_q;
  logic [7:0] read_data_q;

  // Link side wires
  amr_pkg::amr_access_s link_word;
  amr_pkg::amr_access_s link_req;
  logic                 link_word_toggle;
  logic                 link_req_toggle;
  logic                 serial_out;
  logic                 word_sync;
  logic                 req_sync;
  logic                 zero_left_sync;
  logic                 zero_right_sync;

  // Decode
  logic                 word_event;
  logic                 req_event;
  logic [7:0]           read_mux;
  logic                 write_hit;
  logic [2:0]           write_slot;
  logic [7:0]           write_mask;
  logic [7:0]           device_word;

  amr_serial_port u_port (
    .control_bit_clock (control_bit_clock),
    .control_select_n  (control_select_n),
    .control_serial_in (control_serial_in),
    .read_data         (read_data_q),
    .serial_out        (serial_out),
    .word              (link_word),
    .word_toggle       (link_word_toggle),
    .req               (link_req),
    .req_toggle        (link_req_toggle)
  );

  amr_sync_bit #(.RESET_VALUE(1'b0)) u_word_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in (link_word_toggle),
    .sync_out (word_sync)
  );

  amr_sync_bit #(.RESET_VALUE(1'b0)) u_req_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in (link_req_toggle),
    .sync_out (req_sync)
  );

  amr_sync_bit #(.RESET_VALUE(1'b0)) u_zl_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in (left_zero_detect),
    .sync_out (zero_left_sync)
  );

  amr_sync_bit #(.RESET_VALUE(1'b0)) u_zr_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in (right_zero_detect),
    .sync_out (zero_right_sync)
  );

  // Rising flag edges; the word fields were stable for two system clocks before use
  assign word_event = word_sync & ~word_seen_q;
  assign req_event  = req_sync & ~req_seen_q;

  assign device_word = {3'h0, DEVICE_NUMBER} & amr_pkg::MASK_ID;

  // Index decode for reads; any other index returns zero
  always_comb
  begin
    case (link_req.index)
      amr_pkg::IDX_LEFT_ATTEN:  read_mux = reg_q[0];
      amr_pkg::IDX_RIGHT_ATTEN: read_mux = reg_q[1];
      amr_pkg::IDX_FORMAT:      read_mux = reg_q[2];
      amr_pkg::IDX_OUTPUT:      read_mux = reg_q[3];
      amr_pkg::IDX_SYSTEM:      read_mux = reg_q[4];
      amr_pkg::IDX_ZERO_EN:     read_mux = reg_q[5];
      amr_pkg::IDX_ZERO_FLAGS:  read_mux = flags_q;
      amr_pkg::IDX_DEVICE_ID:   read_mux = device_word;
      default:                  read_mux = 8'h00;
    endcase
  end

  // Writes land only on the six writable indices with the direction bit low
  assign write_hit  = !link_word.dir_read
                      && link_word.index >= amr_pkg::IDX_LEFT_ATTEN
                      && link_word.index <= amr_pkg::IDX_ZERO_EN;
  assign write_slot = 3'(link_word.index - amr_pkg::IDX_LEFT_ATTEN);
  assign write_mask = (write_slot == 3'h4) ? amr_pkg::MASK_SYSTEM :
                      (write_slot == 3'h5) ? amr_pkg::MASK_ZERO_EN : 8'hff;

  // Writable registers, one per slot
  for (genvar g = 0; g < amr_pkg::NUM_RW_REGS; g++)
  begin : g_reg
    localparam logic [7:0] RST_VAL = (g < 2)  ? amr_pkg::RST_ATTEN :
                                     (g == 2) ? amr_pkg::RST_FORMAT :
                                     (g == 3) ? amr_pkg::RST_OUTPUT :
                                     (g == 4) ? amr_pkg::RST_SYSTEM :
                                                amr_pkg::RST_ZERO_EN;
    always_ff @(posedge clock)
    begin
      if (sys_rst)
      begin
        reg_q[g] <= RST_VAL;
      end
      else if (word_event && write_hit && write_slot == 3'(g))
      begin
        reg_q[g] <= link_word.data & write_mask;
      end
    end
  end

  // Handshake state, status flags and read capture
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      word_seen_q <= 1'b0;
      req_seen_q  <= 1'b0;
      flags_q     <= 8'h00;
      read_data_q <= 8'h00;
    end
    else
    begin
      word_seen_q <= word_sync;
      req_seen_q  <= req_sync;
      flags_q     <= {6'h00, zero_right_sync, zero_left_sync};
      if (req_event && link_req.dir_read)
      begin
        read_data_q <= read_mux;
      end
    end
  end

  // Decoded controls
  assign left_atten_level  = reg_q[0];
  assign right_atten_level = reg_q[1];
  assign format_ctl        = reg_q[2];
  assign output_ctl = '{
    output_phase_invert:    reg_q[3][7],
    atten_step_rate:        reg_q[3][6:5],
    dac_output_disable:     reg_q[3][4],
    readback_output_enable: reg_q[3][3],
    bypass_stereo_select:   reg_q[3][2] & reg_q[4][4],
    rolloff_select:         reg_q[3][1] & ~reg_q[4][5] & ~reg_q[4][4],
    infinite_zero_mute:     reg_q[3][0] & ~reg_q[4][5]
  };
  assign system_ctl = '{
    system_soft_reset:            reg_q[4][6],
    one_bit_stream_mode:          reg_q[4][5],
    filter_bypass:                reg_q[4][4],
    single_channel_mode:          reg_q[4][3],
    single_channel_source:        reg_q[4][2],
    oversample_rate:              reg_q[4][5] ? amr_pkg::OS_X64 : reg_q[4][1:0],
    analog_fir_rate:              reg_q[4][5] ? reg_q[4][1:0] : 2'h0,
    analog_fir_perf:              reg_q[4][5] ? reg_q[2][3:2] : 2'h0,
    pcm_zero_output_enable:       reg_q[5][0] & ~reg_q[4][5],
    bitstream_zero_output_enable: reg_q[4][5] ? reg_q[5][2:1] : 2'h0
  };

  // Zero pins: with readback enabled, left becomes readback data, right the AND of both channels
  assign left_zero_pin  = reg_q[3][3] ? serial_out : flags_q[0];
  assign right_zero_pin = reg_q[3][3] ? (flags_q[0] & flags_q[1]) : flags_q[1];

endmodule : amr_mode_regs
`default_nettype wire

// [logic/amr_pkg.sv]
// Constants, field layouts and carrier types of the mode register bank.
// Assumes nothing of its surroundings; every other file names these with amr_pkg::.
`default_nettype none
package amr_pkg;

  // Access word layout
  localparam int unsigned WORD_BITS     = 16;
  localparam int unsigned DIR_POS       = 15;
  localparam int unsigned IDX_MSB       = 14;
  localparam int unsigned IDX_LSB       = 8;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned DATA_START_CNT = 8;

  // Register indices
  localparam logic [6:0] IDX_LEFT_ATTEN  = 7'h10;
  localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
  localparam logic [6:0] IDX_FORMAT      = 7'h12;
  localparam logic [6:0] IDX_OUTPUT      = 7'h13;
  localparam logic [6:0] IDX_SYSTEM      = 7'h14;
  localparam logic [6:0] IDX_ZERO_EN     = 7'h15;
  localparam logic [6:0] IDX_ZERO_FLAGS  = 7'h16;
  localparam logic [6:0] IDX_DEVICE_ID   = 7'h17;
  localparam int unsigned NUM_RW_REGS    = 6;

  // Reset values
  localparam logic [7:0] RST_ATTEN   = 8'hff;
  localparam logic [7:0] RST_FORMAT  = 8'h50;
  localparam logic [7:0] RST_OUTPUT  = 8'h00;
  localparam logic [7:0] RST_SYSTEM  = 8'h00;
  localparam logic [7:0] RST_ZERO_EN = 8'h01;

  // Register bit masks; reserved bits stay zero
  localparam logic [7:0] MASK_SYSTEM  = 8'h7f;
  localparam logic [7:0] MASK_ZERO_EN = 8'h07;
  localparam logic [7:0] MASK_FLAGS   = 8'h03;
  localparam logic [7:0] MASK_ID      = 8'h1f;

  // Arbitrary neutral device number
  localparam logic [4:0] DEFAULT_DEVICE_NUMBER = 5'h01;

  // Oversampling encodings
  localparam logic [1:0] OS_X64  = 2'h0;
  localparam logic [1:0] OS_X128 = 2'h1;
  localparam logic [1:0] OS_X32  = 2'h2;

  typedef struct packed {
    logic       dac_output_disable;
    logic       readback_output_enable;
    logic       bypass_stereo_select;
    logic       rolloff_select;
    logic       infinite_zero_mute;
    logic       output_phase_invert;
    logic [1:0] atten_step_rate;
  } amr_output_ctl_s;

  typedef struct packed {
    logic       system_soft_reset;
    logic       one_bit_stream_mode;
    logic       filter_bypass;
    logic       single_channel_mode;
    logic       single_channel_source;
    logic [1:0] oversample_rate;
    logic [1:0] analog_fir_rate;
    logic [1:0] analog_fir_perf;
    logic       pcm_zero_output_enable;
    logic [1:0] bitstream_zero_output_enable;
  } amr_system_ctl_s;

  typedef struct packed {
    logic       atten_load_enable;
    logic [2:0] audio_format_select;
    logic [1:0] deemph_rate_select;
    logic       deemph_enable;
    logic       soft_mute;
  } amr_format_ctl_s;

  // One decoded access word handed across to the system clock
  typedef struct packed {
    logic       dir_read;
    logic [6:0] index;
    logic [7:0] data;
  } amr_access_s;

endpackage : amr_pkg
`default_nettype wire

// [logic/amr_sync_bit.sv]
// Two flip-flop level synchroniser.
// Assumes the input is a level from another clock domain.
`timescale 1ns/1ps
`default_nettype none
module amr_sync_bit #(
  parameter logic RESET_VALUE = 1'b0
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Level
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;
  logic sync_q;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      meta_q <= RESET_VALUE;
      sync_q <= RESET_VALUE;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : amr_sync_bit
`default_nettype wire

// [logic/amr_serial_port.sv]
// Control port shifter on the control bit clock.
// Assumes control_bit_clock idles between frames; a frame ends on select high.
`timescale 1ns/1ps
`default_nettype none
module amr_serial_port (
  // Link pins
  input  wire logic                 control_bit_clock,
  input  wire logic                 control_select_n,
  input  wire logic                 control_serial_in,
  // Readback data, held stable by the system side
  input  wire logic [7:0]           read_data,
  output logic                      serial_out,
  // Completed word; its flag rises with it and falls at the next frame's first clock
  output amr_pkg::amr_access_s      word,
  output logic                      word_toggle,
  // Read request seen after the index bits, flagged the same way
  output amr_pkg::amr_access_s      req,
  output logic                      req_toggle
);

  logic [15:0] shift_q;
  logic [4:0]  count_q;
  logic [7:0]  out_shift_q;
  logic [15:0] shift_d;
  logic        word_toggle_q;
  logic        req_toggle_q;
  amr_pkg::amr_access_s word_q;
  amr_pkg::amr_access_s req_q;

  assign shift_d = {shift_q[14:0], control_serial_in};

  // Counter is cleared by select, so a frame starts clean even with no clock after it
  always_ff @(posedge control_bit_clock or posedge control_select_n)
  begin
    if (control_select_n)
    begin
      count_q <= 5'h00;
    end
    else if (count_q != 5'h1f)
    begin
      count_q <= count_q + 5'h01;
    end
  end

  // Level flags: cleared on the first clock of a frame, set once the field is complete,
  // so they need no reset and stay high across the gap between frames for the synchroniser
  always_ff @(posedge control_bit_clock)
  begin
    shift_q <= shift_d;
    if (!control_select_n && count_q == 5'h00)
    begin
      req_toggle_q  <= 1'b0;
      word_toggle_q <= 1'b0;
    end
    if (!control_select_n && count_q == 5'h07)
    begin
      req_q        <= '{dir_read: shift_d[7], index: shift_d[6:0], data: 8'h00};
      req_toggle_q <= 1'b1;
    end
    if (!control_select_n && count_q == 5'h0f)
    begin
      word_q        <= '{dir_read: shift_d[15], index: shift_d[14:8], data: shift_d[7:0]};
      word_toggle_q <= 1'b1;
    end
  end

  // Readback shifts out on falling edges once the eighth clock has passed
  always_ff @(negedge control_bit_clock)
  begin
    if (count_q == 5'h08)
    begin
      out_shift_q <= read_data;
    end
    else
    begin
      out_shift_q <= {out_shift_q[6:0], 1'b0};
    end
  end

  assign serial_out  = out_shift_q[7];
  assign word        = word_q;
  assign word_toggle = word_toggle_q;
  assign req         = req_q;
  assign req_toggle  = req_toggle_q;

endmodule : amr_serial_port
`default_nettype wire

// [bench/amr_mode_regs_props.sv]
// Port assertions for the mode register bank.
// Assumes it is bound to amr_mode_regs; all checks run on the system clock.
`timescale 1ns/1ps
`default_nettype none
module amr_mode_regs_props (
  // System clock and reset
  input wire logic                     clock,
  input wire logic                     sys_rst,
  // Link pins
  input wire logic                     control_bit_clock,
  input wire logic                     control_select_n,
  input wire logic                     control_serial_in,
  // Zero detection and pins
  input wire logic                     left_zero_detect,
  input wire logic                     right_zero_detect,
  input wire logic                     left_zero_pin,
  input wire logic                     right_zero_pin,
  // Control outputs
  input wire logic [7:0]               left_atten_level,
  input wire logic [7:0]               right_atten_level,
  input wire amr_pkg::amr_format_ctl_s format_ctl,
  input wire amr_pkg::amr_output_ctl_s output_ctl,
  input wire amr_pkg::amr_system_ctl_s system_ctl
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  wire rb_en;
  assign rb_en = output_ctl.readback_output_enable;

  a_reset_atten: assert property ($fell(sys_rst) |-> left_atten_level == amr_pkg::RST_ATTEN
    && right_atten_level == amr_pkg::RST_ATTEN) else $error("attenuation not at reset value");
  a_reset_ctl: assert property ($fell(sys_rst) |-> format_ctl == amr_pkg::RST_FORMAT
    && output_ctl == amr_pkg::RST_OUTPUT && system_ctl.pcm_zero_output_enable) else $error("control reset wrong");
  a_reset_mode: assert property ($fell(sys_rst) |-> !system_ctl.system_soft_reset
    && !system_ctl.one_bit_stream_mode && !system_ctl.filter_bypass && !system_ctl.single_channel_mode
    && !system_ctl.single_channel_source && system_ctl.oversample_rate == amr_pkg::OS_X64)
    else $error("mode reset wrong");
  a_write_in_frame: assert property (!$past(sys_rst) && $changed(left_atten_level)
    |-> !$past(control_select_n, 8)) else $error("attenuation changed without a frame");
  a_left_mirror: assert property ((!rb_en && $stable(left_zero_detect))[*6]
    |-> left_zero_pin == left_zero_detect) else $error("left pin not the left flag");
  a_right_mirror: assert property ((!rb_en && $stable(right_zero_detect))[*6]
    |-> right_zero_pin == right_zero_detect) else $error("right pin not the right flag");
  a_and_pin: assert property ((rb_en && $stable({left_zero_detect, right_zero_detect}))[*6]
    |-> right_zero_pin == (left_zero_detect && right_zero_detect)) else $error("right pin not flag AND");
  a_stream_rate: assert property (system_ctl.one_bit_stream_mode
    |-> system_ctl.oversample_rate == amr_pkg::OS_X64) else $error("stream mode kept oversampling");
endmodule : amr_mode_regs_props

bind amr_mode_regs amr_mode_regs_props u_props (.clock, .sys_rst, .control_bit_clock, .control_select_n,
  .control_serial_in, .left_zero_detect, .right_zero_detect, .left_zero_pin, .right_zero_pin,
  .left_atten_level, .right_atten_level, .format_ctl, .output_ctl, .system_ctl);
`default_nettype wire

// [bench/amr_host_model.sv]
// Host controller model for the three-wire control port.
// Assumes one caller at a time; readback needs a slow bit clock.
`timescale 1ns/1ps
`default_nettype none
module amr_host_model (
  // Link pins
  output var logic       control_bit_clock,
  output var logic       control_select_n,
  output var logic       control_serial_in,
  input  wire logic      left_zero_pin,
  // Readback result
  output var logic [7:0] rd_data,
  output var logic       rd_done
);
  initial
  begin
    control_bit_clock = 1'b0;
    control_select_n  = 1'b1;
    control_serial_in = 1'b0;
    rd_data           = 8'h00;
    rd_done           = 1'b0;
  end

  // One word MSB first; the bit clock idles low outside frames
  task automatic frame(input logic [15:0] w, input realtime half);
    control_select_n = 1'b0;
    #(half);
    for (int i = 15; i >= 0; i--)
    begin
      control_serial_in = w[i];
      #(half);
      if (i < 8)
        rd_data[i] = left_zero_pin;
      control_bit_clock = 1'b1;
      #(half);
      control_bit_clock = 1'b0;
    end
    #(half);
    control_select_n  = 1'b1;
    control_serial_in = ~control_serial_in;
    rd_done           = w[15];
    #(half + 40.0);
    rd_done = 1'b0;
  endtask : frame
endmodule : amr_host_model
`default_nettype wire

// [bench/test_audio_dac_mode_register_bank.sv]
// Self-checking bench for the mode register bank.
// Assumes the host model drives the link pins; reads use a 120 ns bit clock.
`timescale 1ns/1ps
`default_nettype none
module test_audio_dac_mode_register_bank;
  logic                     clock = 1'b0;
  logic                     sys_rst = 1'b1;
  logic                     left_zero_detect = 1'b0;
  logic                     right_zero_detect = 1'b0;
  wire logic                control_bit_clock, control_select_n, control_serial_in;
  wire logic                left_zero_pin, right_zero_pin, rd_done;
  wire logic [7:0]          left_atten_level, right_atten_level, rd_data;
  amr_pkg::amr_format_ctl_s format_ctl;
  amr_pkg::amr_output_ctl_s output_ctl;
  amr_pkg::amr_system_ctl_s system_ctl;
  logic [7:0]               exp_q[$];
  logic [7:0]               dflt[8];
  logic [7:0]               v, la;
  int                       bad_count = 0;
  int                       n_tests = 0;

  always #2 clock = ~clock;

  amr_mode_regs uut (.clock, .sys_rst, .control_bit_clock, .control_select_n, .control_serial_in,
    .left_zero_detect, .right_zero_detect, .left_zero_pin, .right_zero_pin, .left_atten_level,
    .right_atten_level, .format_ctl, .output_ctl, .system_ctl);
  amr_host_model host (.control_bit_clock, .control_select_n, .control_serial_in, .left_zero_pin,
    .rd_data, .rd_done);

  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    host.frame({1'b0, idx, d}, 3.0);
    repeat (8) @(posedge clock);
    #1;
  endtask : wr

  task automatic rd(input logic [6:0] idx, input logic [7:0] e);
    exp_q.push_back(e);
    host.frame({1'b1, idx, 8'h00}, 60.0);
    repeat (4) @(posedge clock);
    #1;
  endtask : rd

  task automatic conclude;
    $display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // Each readback takes the oldest expectation
  always @(posedge rd_done)
  begin
    if (exp_q.size() == 0)
      check("readback queue", 8'h01, 8'h00);
    else
      check("readback", exp_q.pop_front(), rd_data);
  end

  initial
  begin
    for (int c = 0; c < 60000; c++)
      @(posedge clock);
    check("run length", 8'h00, 8'hff);
    conclude();
  end

  initial
  begin
    void'($urandom(87));
    dflt = '{amr_pkg::RST_ATTEN, amr_pkg::RST_ATTEN, amr_pkg::RST_FORMAT, 8'h08, amr_pkg::RST_SYSTEM,
      amr_pkg::RST_ZERO_EN, 8'h00, {3'h0, amr_pkg::DEFAULT_DEVICE_NUMBER}};
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    // Priming frame to an unmapped index
    wr(7'h30, 8'h00);
    check("left atten", amr_pkg::RST_ATTEN, left_atten_level);
    check("output ctl", amr_pkg::RST_OUTPUT, output_ctl);
    check("pcm zero", 8'h01, {7'h0, system_ctl.pcm_zero_output_enable});
    wr(amr_pkg::IDX_OUTPUT, 8'h08);
    check("readback enable", 8'h01, {7'h0, output_ctl.readback_output_enable});
    for (int i = 0; i < 8; i++)
      rd(7'h10 + 7'(i), dflt[i]);
    rd(7'h7f, 8'h00);
    $display("Test defaults done");
    for (int k = 0; k < 4; k++)
    begin
      v = 8'($urandom()) | ((k == 3) ? 8'h0f : 8'h00);
      if (k == 0)
        la = v;
      wr(7'h10 + 7'(k), v);
      if (k < 2)
        check("atten level", v, (k == 1) ? right_atten_level : left_atten_level);
      rd(7'h10 + 7'(k), v);
    end
    check("pcm output ctl", {v[4], v[3], 1'b0, v[1], v[0], v[7], v[6:5]}, output_ctl);
    $display("Test random writes done");
    wr(amr_pkg::IDX_SYSTEM, 8'hdf);
    rd(amr_pkg::IDX_SYSTEM, 8'h5f);
    check("bypass", 8'h01, {7'h0, system_ctl.filter_bypass});
    check("soft reset", 8'h01, {7'h0, system_ctl.system_soft_reset});
    check("bypass gating", 8'h02, {6'h0, output_ctl.bypass_stereo_select, output_ctl.rolloff_select});
    check("single_channel_mode", 8'h03, {6'h0, system_ctl.single_channel_mode, system_ctl.single_channel_source});
    foreach (dflt[i])
      if (i < 3)
      begin
        v = {6'h0, 2'(i)};
        wr(amr_pkg::IDX_SYSTEM, v);
        check("oversample", v, {6'h0, system_ctl.oversample_rate});
      end
    wr(amr_pkg::IDX_FORMAT, 8'h58);
    check("format", 8'h58, format_ctl);
    wr(amr_pkg::IDX_SYSTEM, 8'h21);
    check("stream gating", 8'h00, {6'h0, output_ctl.infinite_zero_mute, output_ctl.rolloff_select});
    check("stream", 8'h01, {7'h0, system_ctl.one_bit_stream_mode});
    check("fir rate", 8'h01, {6'h0, system_ctl.analog_fir_rate});
    check("fir perf", 8'h02, {6'h0, system_ctl.analog_fir_perf});
    wr(amr_pkg::IDX_SYSTEM, 8'h00);
    wr(amr_pkg::IDX_ZERO_EN, 8'hfe);
    rd(amr_pkg::IDX_ZERO_EN, 8'h06);
    check("pcm zero off", 8'h00, {7'h0, system_ctl.pcm_zero_output_enable});
    check("stream zero off", 8'h00, {6'h0, system_ctl.bitstream_zero_output_enable});
    wr(amr_pkg::IDX_SYSTEM, 8'h20);
    check("stream zero", 8'h03, {6'h0, system_ctl.bitstream_zero_output_enable});
    $display("Test modes done");
    wr(amr_pkg::IDX_ZERO_FLAGS, 8'hff);
    wr(amr_pkg::IDX_DEVICE_ID, 8'hea);
    wr(7'h08, 8'h12);
    rd(amr_pkg::IDX_ZERO_FLAGS, 8'h00);
    rd(amr_pkg::IDX_DEVICE_ID, dflt[7]);
    rd(amr_pkg::IDX_LEFT_ATTEN, la);
    rd(7'h08, 8'h00);
    $display("Test refused writes done");
    @(posedge clock);
    left_zero_detect <= 1'b1;
    repeat (6) @(posedge clock);
    rd(amr_pkg::IDX_ZERO_FLAGS, 8'h01);
    check("and pin low", 8'h00, {7'h0, right_zero_pin});
    @(posedge clock);
    right_zero_detect <= 1'b1;
    repeat (6) @(posedge clock);
    check("and pin high", 8'h01, {7'h0, right_zero_pin});
    rd(amr_pkg::IDX_ZERO_FLAGS, 8'h03);
    wr(amr_pkg::IDX_OUTPUT, 8'h00);
    @(posedge clock);
    left_zero_detect <= 1'b0;
    repeat (6) @(posedge clock);
    check("flag pins", 8'h01, {6'h0, left_zero_pin, right_zero_pin});
    $display("Test zero flags done");
    check("queue empty", 8'h00, 8'(exp_q.size()));
    conclude();
  end
endmodule : test_audio_dac_mode_register_bank
`default_nettype wire
